// File: rtl/tkc_pkg.sv
// Purpose: Shared constants and types for the touch-key control block
// Assumes: 250 MHz reference clock, byte-wide register port
// Notes:
// Functional notes
// - Bit 7 shows calibration in progress
// - Bit 6 set when acquisition exceeds 16 ms
// - Bit 1 slider detect, bit 0 key detect
// - Slider detect also sets keys 0-2, key flag
// - Twelve key bits, touched reads one
// - Change line low on status change
// - Nonzero write to address 6 calibrates
// - Calibration flag set at start, cleared at end
// - Nonzero write to address 7 resets
// - Burst spacing is setting times 16 ms
// - Interval zero powers down, nonzero wakes
// - Reset command still works while powered down
// - Interval setting resets to one
// - Drift only while key not in detect
// - No drift once past negative threshold
// - Two 7-bit drift rates, 0.16 s steps
// - Drift rate zero disables that direction
// - Detect after integrator count consecutive hits
// - Long detection triggers automatic key recalibration
// - Recal delay resets per mode strap
// - Detection suspends all drift for hold time
`default_nettype none

package tkc_pkg;
    localparam int NKEYS = 12;
    // Time base
    localparam int CLK_PERIOD_NS = 4;
    localparam int INTERVAL_NS   = 16_000_000;
    localparam int INTERVAL_CYC  = INTERVAL_NS / CLK_PERIOD_NS;
    localparam int INTERVAL_MS   = 16;
    localparam int STEP_MS       = 160;
    localparam logic [3:0] STEP_TICKS = 4'(STEP_MS / INTERVAL_MS);
    // Register offsets
    localparam logic [7:0] ADDR_CHIP_IDENTITY = 8'h00;
    localparam logic [7:0] ADDR_FW_VER  = 8'h01;
    localparam logic [7:0] ADDR_SUMMARY = 8'h02;
    localparam logic [7:0] ADDR_KEY_LO  = 8'h03;
    localparam logic [7:0] ADDR_KEY_HI  = 8'h04;
    localparam logic [7:0] ADDR_SLIDER  = 8'h05;
    localparam logic [7:0] ADDR_CAL     = 8'h06;
    localparam logic [7:0] ADDR_RESET   = 8'h07;
    localparam logic [7:0] ADDR_LP      = 8'h08;
    localparam logic [7:0] ADDR_TTD     = 8'h09;
    localparam logic [7:0] ADDR_ATD     = 8'h0a;
    localparam logic [7:0] ADDR_DI      = 8'h0b;
    localparam logic [7:0] ADDR_TRD     = 8'h0c;
    localparam logic [7:0] ADDR_DHT     = 8'h0d;
    // Summary bit positions
    localparam int CAL_BIT  = 7;
    localparam int OVF_BIT  = 6;
    localparam int SLIDER_IN_DETECT_BIT = 1;
    localparam int ANY_KEY_IN_DETECT_BIT = 0;
    // Reset values
    localparam logic [7:0] LP_RST        = 8'h01;
    localparam logic [6:0] TTD_RST       = 7'h14;
    localparam logic [6:0] ATD_RST       = 7'h05;
    localparam logic [7:0] DI_RST        = 8'h04;
    localparam logic [7:0] DI_MAX        = 8'h20;
    localparam logic [7:0] TRD_RST_COMMS = 8'h00;
    localparam logic [7:0] TRD_RST_SA    = 8'hff;
    localparam logic [7:0] DHT_RST       = 8'h19;
    localparam logic [1:0] INIT_LOAD     = 2'h2;
    // Identity bytes, values arbitrary
    localparam logic [7:0] CHIP_IDENTITY_VAL = 8'h5a;
    localparam logic [7:0] FW_VER_VAL  = 8'h10;

    typedef enum logic [3:0] {
        ST_WAIT = 4'b0001,
        ST_ACQ  = 4'b0010,
        ST_CAL  = 4'b0100,
        ST_PDN  = 4'b1000
    } tkc_state_e;

    // Per-burst results from the acquisition engine
    typedef struct packed {
        logic [NKEYS-1:0] over_thr;
        logic [NKEYS-1:0] past_neg;
        logic [NKEYS-1:0] above_ref;
        logic [NKEYS-1:0] below_ref;
        logic             slider_det;
        logic [7:0]       slider_pos;
    } tkc_meas_s;

    // One-step reference adjust requests
    typedef struct packed {
        logic [NKEYS-1:0] up;
        logic [NKEYS-1:0] down;
    } tkc_drift_s;
endpackage : tkc_pkg

`default_nettype wire

// File: rtl/tkc_ctrl.sv
// Purpose: Register bank, burst timing, detection and drift control
// Assumes: Byte register port from a same-clock serial engine
// Notes: Change line releases when host reads bytes 2 to 5
`default_nettype none

module tkc_ctrl #(
    parameter int INTERVAL_CYC_P = tkc_pkg::INTERVAL_CYC
) (
    input  wire logic                      ref_clk_i,
    input  wire logic                      resetn_i,
    input  wire logic                      mode_pin_i,
    input  wire logic [7:0]                reg_addr_i,
    input  wire logic [7:0]                reg_wdata_i,
    input  wire logic                      reg_wr_i,
    input  wire logic                      reg_rd_i,
    output logic      [7:0]                reg_rdata_o,
    input  wire tkc_pkg::tkc_meas_s        meas_i,
    input  wire logic                      acq_done_i,
    input  wire logic                      calib_done_i,
    output logic                           burst_start_o,
    output logic                           calib_start_o,
    output logic                           soft_reset_o,
    output logic                           power_down_o,
    output tkc_pkg::tkc_drift_s            drift_o,
    output logic      [tkc_pkg::NKEYS-1:0] key_recal_o,
    output logic                           change_n_o
);
    import tkc_pkg::*;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    // Write decode, shared by both commands
    function automatic logic cmd_hit(input logic [7:0] a, input logic [7:0] t,
                                     input logic we, input logic [7:0] d);
        return we && (a == t) && (d != 8'h00);
    endfunction : cmd_hit

    logic cal_cmd;
    logic rst_cmd;
    assign cal_cmd = cmd_hit(reg_addr_i, ADDR_CAL, reg_wr_i, reg_wdata_i);
    assign rst_cmd = cmd_hit(reg_addr_i, ADDR_RESET, reg_wr_i, reg_wdata_i);

    // Mode strap synchroniser and load delay
    logic       mode_s1_r;
    logic       mode_s2_r;
    logic [1:0] init_r;
    logic [1:0] init_nxt;
    always_comb begin
        init_nxt = (init_r == 2'h3) ? init_r : init_r + 2'h1;
    end
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_s1_r <= 1'b0;
            mode_s2_r <= 1'b0;
            init_r    <= 2'h0;
        end else begin
            mode_s1_r <= mode_pin_i;
            mode_s2_r <= mode_s1_r;
            init_r    <= init_nxt;
        end
    end

    // Configuration registers
    logic [7:0] lp_r, lp_nxt, di_r, di_nxt, trd_r, trd_nxt, dht_r, dht_nxt;
    logic [6:0] ttd_r, ttd_nxt, atd_r, atd_nxt;
    logic [7:0] trd_strap;
    assign trd_strap = mode_s2_r ? TRD_RST_SA : TRD_RST_COMMS;
    always_comb begin
        lp_nxt  = lp_r;
        ttd_nxt = ttd_r;
        atd_nxt = atd_r;
        di_nxt  = di_r;
        trd_nxt = trd_r;
        dht_nxt = dht_r;
        if (rst_cmd) begin
            lp_nxt  = LP_RST;
            ttd_nxt = TTD_RST;
            atd_nxt = ATD_RST;
            di_nxt  = DI_RST;
            trd_nxt = trd_strap;
            dht_nxt = DHT_RST;
        end else if (init_r == INIT_LOAD) begin
            trd_nxt = trd_strap;
        end else if (reg_wr_i) begin
            // Identity, status and command bytes hold nothing to write
            case (reg_addr_i)
                ADDR_LP:  lp_nxt  = reg_wdata_i;
                ADDR_TTD: ttd_nxt = reg_wdata_i[6:0];
                ADDR_ATD: atd_nxt = reg_wdata_i[6:0];
                ADDR_DI:  di_nxt  = reg_wdata_i;
                ADDR_TRD: trd_nxt = reg_wdata_i;
                ADDR_DHT: dht_nxt = reg_wdata_i;
                default:  ;
            endcase
        end
    end
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lp_r  <= LP_RST;
            ttd_r <= TTD_RST;
            atd_r <= ATD_RST;
            di_r  <= DI_RST;
            trd_r <= TRD_RST_COMMS;
            dht_r <= DHT_RST;
        end else begin
            lp_r  <= lp_nxt;
            ttd_r <= ttd_nxt;
            atd_r <= atd_nxt;
            di_r  <= di_nxt;
            trd_r <= trd_nxt;
            dht_r <= dht_nxt;
        end
    end

    // Free 0.16 s step divider, independent of burst timing
    logic [31:0] base_r, base_nxt;
    logic [3:0]  sdiv_r, sdiv_nxt;
    logic        base_wrap;
    logic        step_tick;
    assign base_wrap = (base_r == 32'(INTERVAL_CYC_P - 1));
    assign step_tick = base_wrap && (sdiv_r == STEP_TICKS - 4'h1);
    always_comb begin
        base_nxt = base_wrap ? 32'h0 : base_r + 32'h1;
        sdiv_nxt = sdiv_r;
        if (base_wrap) begin
            sdiv_nxt = (sdiv_r == STEP_TICKS - 4'h1) ? 4'h0 : sdiv_r + 4'h1;
        end
    end
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            base_r <= 32'h0;
            sdiv_r <= 4'h0;
        end else begin
            base_r <= base_nxt;
            sdiv_r <= sdiv_nxt;
        end
    end

    // Burst sequencer; interval counts from the end of the last burst
    tkc_state_e  st_r, st_nxt;
    logic [31:0] cyc_r, cyc_nxt;
    logic [7:0]  ivl_r, ivl_nxt;
    logic        ovf_r, ovf_nxt, cal_r, cal_nxt;
    logic        burst_r, burst_nxt, calst_r, calst_nxt, srst_r, pdn_r;
    logic        tick;
    assign tick = (cyc_r == 32'(INTERVAL_CYC_P - 1));
    always_comb begin
        st_nxt    = st_r;
        cyc_nxt   = tick ? 32'h0 : cyc_r + 32'h1;
        ivl_nxt   = (tick && ivl_r != 8'hff) ? ivl_r + 8'h1 : ivl_r;
        ovf_nxt   = ovf_r;
        cal_nxt   = cal_r;
        burst_nxt = 1'b0;
        calst_nxt = 1'b0;
        case (st_r)
            ST_WAIT: begin
                if (lp_r == 8'h00) begin
                    st_nxt = ST_PDN;
                end else if (ivl_r >= lp_r) begin
                    st_nxt    = ST_ACQ;
                    burst_nxt = 1'b1;
                    cyc_nxt   = 32'h0;
                    ivl_nxt   = 8'h00;
                end
            end
            ST_ACQ: begin
                if (acq_done_i) begin
                    ovf_nxt = (ivl_r != 8'h00);
                    st_nxt  = ST_WAIT;
                    cyc_nxt = 32'h0;
                    ivl_nxt = 8'h00;
                end
            end
            ST_CAL: begin
                if (calib_done_i) begin
                    cal_nxt = 1'b0;
                    st_nxt  = ST_WAIT;
                    cyc_nxt = 32'h0;
                    ivl_nxt = 8'h00;
                end
            end
            ST_PDN: begin
                if (lp_r != 8'h00) begin
                    st_nxt  = ST_WAIT;
                    cyc_nxt = 32'h0;
                    ivl_nxt = 8'h00;
                end
            end
            default: st_nxt = ST_WAIT;
        endcase
        // Calibration preempts a running burst
        if (cal_cmd) begin
            st_nxt    = ST_CAL;
            cal_nxt   = 1'b1;
            calst_nxt = 1'b1;
        end
        if (rst_cmd) begin
            st_nxt    = ST_WAIT;
            cyc_nxt   = 32'h0;
            ivl_nxt   = 8'h00;
            ovf_nxt   = 1'b0;
            cal_nxt   = 1'b0;
            calst_nxt = 1'b0;
        end
    end
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r    <= ST_WAIT;
            cyc_r   <= 32'h0;
            ivl_r   <= 8'h00;
            ovf_r   <= 1'b0;
            cal_r   <= 1'b0;
            burst_r <= 1'b0;
            calst_r <= 1'b0;
            srst_r  <= 1'b0;
            pdn_r   <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            cyc_r   <= cyc_nxt;
            ivl_r   <= ivl_nxt;
            ovf_r   <= ovf_nxt;
            cal_r   <= cal_nxt;
            burst_r <= burst_nxt;
            calst_r <= calst_nxt;
            srst_r  <= rst_cmd;
            pdn_r   <= (st_nxt == ST_PDN);
        end
    end

    // Integrator target, clamped to 1..32
    logic [7:0] di_eff;
    assign di_eff = (di_r == 8'h00) ? 8'h01 : (di_r > DI_MAX) ? DI_MAX : di_r;
    logic samp;
    assign samp = acq_done_i && (st_r == ST_ACQ);

    // Per-key detect integrator and recal timer
    // Per-key bits are gathered on nets so each flop has one owning process
    wire logic [NKEYS-1:0] det_r;
    wire logic [NKEYS-1:0] det_nv;
    wire logic [NKEYS-1:0] recal_r;
    genvar k;
    generate
        for (k = 0; k < NKEYS; k++) begin : g_key
            logic [7:0] integ_r, integ_nxt, dur_r, dur_nxt;
            logic       dk_r, dk_nxt, rc_r, rc_nxt;
            assign det_r[k]   = dk_r;
            assign det_nv[k]  = dk_nxt;
            assign recal_r[k] = rc_r;
            always_comb begin
                integ_nxt = integ_r;
                dur_nxt   = dur_r;
                dk_nxt    = dk_r;
                rc_nxt    = 1'b0;
                if (samp) begin
                    if (meas_i.over_thr[k]) begin
                        integ_nxt = (integ_r < di_eff) ? integ_r + 8'h01 : integ_r;
                    end else begin
                        integ_nxt = 8'h00;
                    end
                    dk_nxt = (integ_nxt >= di_eff);
                end
                if (!dk_r) begin
                    dur_nxt = 8'h00;
                end else if (step_tick && dur_r != 8'hff) begin
                    dur_nxt = dur_r + 8'h01;
                end
                // Zero delay means never time out
                if (dk_r && trd_r != 8'h00 && dur_r >= trd_r) begin
                    rc_nxt    = 1'b1;
                    dk_nxt    = 1'b0;
                    integ_nxt = 8'h00;
                    dur_nxt   = 8'h00;
                end
                if (rst_cmd) begin
                    integ_nxt = 8'h00;
                    dur_nxt   = 8'h00;
                    dk_nxt    = 1'b0;
                    rc_nxt    = 1'b0;
                end
            end
            always_ff @(posedge ref_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    integ_r <= 8'h00;
                    dur_r   <= 8'h00;
                    dk_r    <= 1'b0;
                    rc_r    <= 1'b0;
                end else begin
                    integ_r <= integ_nxt;
                    dur_r   <= dur_nxt;
                    dk_r    <= dk_nxt;
                    rc_r    <= rc_nxt;
                end
            end
        end
    endgenerate

    // Drift rate timers and hold-off
    logic [6:0] tt_r, tt_nxt, at_r, at_nxt;
    logic [7:0] hold_r, hold_nxt;
    logic       tt_fire, at_fire;
    tkc_drift_s drift_r, drift_nxt;
    assign tt_fire = step_tick && (ttd_r != 7'h00) && (tt_r + 7'h01 >= ttd_r);
    assign at_fire = step_tick && (atd_r != 7'h00) && (at_r + 7'h01 >= atd_r);
    always_comb begin
        tt_nxt = tt_r;
        at_nxt = at_r;
        if (step_tick) begin
            tt_nxt = tt_fire ? 7'h00 : tt_r + 7'h01;
            at_nxt = at_fire ? 7'h00 : at_r + 7'h01;
        end
        hold_nxt = hold_r;
        if (|(det_nv & ~det_r) && dht_r != 8'h00) begin
            hold_nxt = dht_r;
        end else if (step_tick && hold_r != 8'h00) begin
            hold_nxt = hold_r - 8'h01;
        end
        // Touched or sunk keys keep their reference
        drift_nxt.up   = {NKEYS{tt_fire && hold_r == 8'h00}} & ~det_r
                         & ~meas_i.past_neg & meas_i.above_ref;
        drift_nxt.down = {NKEYS{at_fire && hold_r == 8'h00}} & ~det_r
                         & ~meas_i.past_neg & meas_i.below_ref;
        if (rst_cmd) begin
            tt_nxt    = 7'h00;
            at_nxt    = 7'h00;
            hold_nxt  = 8'h00;
            drift_nxt = '0;
        end
    end
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tt_r    <= 7'h00;
            at_r    <= 7'h00;
            hold_r  <= 8'h00;
            drift_r <= '0;
        end else begin
            tt_r    <= tt_nxt;
            at_r    <= at_nxt;
            hold_r  <= hold_nxt;
            drift_r <= drift_nxt;
        end
    end

    // Status bytes and change line
    logic             slider_in_detect_r, slider_in_detect_nxt;
    logic [7:0]       spos_r, spos_nxt;
    logic [NKEYS-1:0] key_stat;
    logic [7:0]       summary;
    logic [31:0]      stat, prev_r;
    logic             chg_n_r, chg_n_nxt;
    assign key_stat = det_r | {{(NKEYS-3){1'b0}}, {3{slider_in_detect_r}}};
    always_comb begin
        summary           = 8'h00;
        summary[CAL_BIT]  = cal_r;
        summary[OVF_BIT]  = ovf_r;
        summary[SLIDER_IN_DETECT_BIT] = slider_in_detect_r;
        summary[ANY_KEY_IN_DETECT_BIT] = |key_stat;
    end
    assign stat = {summary, key_stat[7:0], 4'h0, key_stat[11:8], spos_r};
    always_comb begin
        slider_in_detect_nxt  = samp ? meas_i.slider_det : slider_in_detect_r;
        spos_nxt  = samp ? meas_i.slider_pos : spos_r;
        chg_n_nxt = chg_n_r;
        if (reg_rd_i && reg_addr_i >= ADDR_SUMMARY && reg_addr_i <= ADDR_SLIDER) begin
            chg_n_nxt = 1'b1;
        end
        // A change in the read cycle still pulls the line
        if (stat != prev_r) begin
            chg_n_nxt = 1'b0;
        end
        if (rst_cmd) begin
            slider_in_detect_nxt = 1'b0;
            spos_nxt = 8'h00;
        end
    end
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            slider_in_detect_r  <= 1'b0;
            spos_r  <= 8'h00;
            prev_r  <= 32'h0;
            chg_n_r <= 1'b1;
        end else begin
            slider_in_detect_r  <= slider_in_detect_nxt;
            spos_r  <= spos_nxt;
            prev_r  <= stat;
            chg_n_r <= chg_n_nxt;
        end
    end

    // Read mux, registered on the read strobe
    logic [7:0] rdata_r, rdata_nxt;
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_CHIP_IDENTITY: rdata_nxt = CHIP_IDENTITY_VAL;
                ADDR_FW_VER:  rdata_nxt = FW_VER_VAL;
                ADDR_SUMMARY: rdata_nxt = summary;
                ADDR_KEY_LO:  rdata_nxt = key_stat[7:0];
                ADDR_KEY_HI:  rdata_nxt = {4'h0, key_stat[11:8]};
                ADDR_SLIDER:  rdata_nxt = spos_r;
                ADDR_LP:      rdata_nxt = lp_r;
                ADDR_TTD:     rdata_nxt = {1'b0, ttd_r};
                ADDR_ATD:     rdata_nxt = {1'b0, atd_r};
                ADDR_DI:      rdata_nxt = di_r;
                ADDR_TRD:     rdata_nxt = trd_r;
                ADDR_DHT:     rdata_nxt = dht_r;
                default:      rdata_nxt = 8'h00;
            endcase
        end
    end
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o   = rdata_r;
    assign burst_start_o = burst_r;
    assign calib_start_o = calst_r;
    assign soft_reset_o  = srst_r;
    assign power_down_o  = pdn_r;
    assign drift_o       = drift_r;
    assign key_recal_o   = recal_r;
    assign change_n_o    = chg_n_r;

    // Checks
    a_cal_flag_set: assert property (cal_cmd && !rst_cmd |=> cal_r && calib_start_o)
        else $error("calibration flag not set by command");
    a_cal_flag_held: assert property (cal_r && !calib_done_i && !rst_cmd |=> cal_r)
        else $error("calibration flag dropped early");
    a_cal_flag_end: assert property (st_r == ST_CAL && calib_done_i && !cal_cmd && !rst_cmd
        |=> !cal_r && st_r == ST_WAIT)
        else $error("calibration flag not cleared at end");
    a_reset_cmd: assert property (rst_cmd |=> soft_reset_o && lp_r == LP_RST && st_r == ST_WAIT)
        else $error("reset command not honoured");
    a_pdn_reset: assert property (power_down_o && rst_cmd |=> soft_reset_o ##1 !power_down_o)
        else $error("reset ignored in power-down");
    a_pdn_entry: assert property (st_r == ST_WAIT && lp_r == 8'h00 && !cal_cmd && !rst_cmd
        |=> power_down_o)
        else $error("zero interval did not power down");
    a_change_line: assert property (stat != prev_r |=> !change_n_o)
        else $error("change line not pulled low");
    a_ro_ignored: assert property (reg_wr_i && reg_addr_i <= ADDR_SLIDER && !rst_cmd && init_r == 2'h3
        |=> $stable(lp_r) && $stable(dht_r))
        else $error("read-only write altered a setting");
    a_drift_touch: assert property (((drift_o.up | drift_o.down) & $past(det_r)) == '0)
        else $error("drift on a key in detect");
    a_drift_hold: assert property (hold_r != 8'h00 |=> drift_o == '0)
        else $error("drift during hold time");
    a_recal_clear: assert property (|key_recal_o |-> (key_recal_o & det_r) == '0)
        else $error("recalibrated key still in detect");
endmodule : tkc_ctrl

`default_nettype wire

// File: testbench/tkc_acq_model.sv
// Purpose: Acquisition engine stand-in that answers burst and calibration starts
// Assumes: Starts are one-cycle pulses from the control block
// Notes: Fixed latencies; stretch makes a burst outlast one interval
`default_nettype none

module tkc_acq_model #(
    parameter int ACQ_CYC = 3,
    parameter int LONG_CYC = 30,
    parameter int CAL_CYC = 10
) (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic burst_i,
    input  wire logic cal_i,
    input  wire logic stretch_i,
    output logic      acq_done_o,
    output logic      cal_done_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int acq_cnt;
    int cal_cnt;

    // Count down from each start and pulse done once; zero means idle
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acq_cnt <= 0;
            cal_cnt <= 0;
        end else begin
            acq_cnt <= burst_i ? (stretch_i ? LONG_CYC : ACQ_CYC) : (acq_cnt > 0 ? acq_cnt - 1 : 0);
            cal_cnt <= cal_i ? CAL_CYC : (cal_cnt > 0 ? cal_cnt - 1 : 0);
        end
    end
    assign acq_done_o = (acq_cnt == 1);
    assign cal_done_o = (cal_cnt == 1);
endmodule : tkc_acq_model

`default_nettype wire

// File: testbench/tb.sv
// Purpose: Register-level checks of the touch-key control block
// Assumes: Comms strap until the last test, interval shortened to 20 cycles
// Notes: Expected values come from the register table
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import tkc_pkg::*;
    logic       clk = 0, rst_n = 0, wr = 0, rd = 0, acq, cal, bst, cst, pdn, srst, chg_n;
    logic       mode = 0, stretch = 0;
    logic [7:0] addr = 0, wd = 0, rdat;
    tkc_meas_s  meas = '0;
    tkc_drift_s drift;
    logic [11:0] recal, up_seen, dn_seen, rc_seen;
    int         err_count = 0, tests_run = 0, cyc = 0;
    logic [7:0] rst_tab [6] = '{8'h01, 8'h14, 8'h05, 8'h04, 8'h00, 8'h19};

    // Short interval keeps bursts 20 cycles apart
    tkc_ctrl #(.INTERVAL_CYC_P(20)) tkc_ctrl_inst (
        .ref_clk_i(clk), .resetn_i(rst_n), .mode_pin_i(mode), .reg_addr_i(addr),
        .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .meas_i(meas),
        .acq_done_i(acq), .calib_done_i(cal), .burst_start_o(bst), .calib_start_o(cst),
        .soft_reset_o(srst), .power_down_o(pdn), .drift_o(drift), .key_recal_o(recal), .change_n_o(chg_n));
    tkc_acq_model tkc_acq_model_inst (.clk_i(clk), .resetn_i(rst_n), .burst_i(bst),
        .cal_i(cst), .stretch_i(stretch), .acq_done_o(acq), .cal_done_o(cal));

    initial forever #2 clk = ~clk;
    // Hang guard, far above the under two thousand cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wreg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wd <= v;
        @(posedge clk);
        wr <= 0;
    endtask : wreg

    // Read data lands one cycle after the strobe edge
    task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1;
        chk(rdat & m, e);
    endtask : rchk

    // Status settles one cycle after done, change line one more
    task automatic wait_acq;
        int k = 0;
        do begin
            @(posedge clk);
            #1;
        end while (acq !== 1'b1 && ++k < 100);
        repeat (2) @(posedge clk);
        #1;
    endtask : wait_acq

    // Collect drift and recal pulses; each stands for one cycle only
    task automatic watch(input int n);
        up_seen = '0;
        dn_seen = '0;
        rc_seen = '0;
        repeat (n) begin
            @(posedge clk);
            #1;
            up_seen |= drift.up;
            dn_seen |= drift.down;
            rc_seen |= recal;
        end
    endtask : watch

    task automatic pdn_chk(input logic [7:0] v, input logic e);
        wreg(ADDR_LP, v);
        repeat (60) @(posedge clk);
        #1;
        chk({7'h0, pdn}, {7'h0, e});
    endtask : pdn_chk

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1;
        repeat (4) @(posedge clk);
        rchk(ADDR_CHIP_IDENTITY, CHIP_IDENTITY_VAL);
        for (int i = 0; i < 6; i++) rchk(ADDR_LP + 8'(i), rst_tab[i]);
        wreg(ADDR_CHIP_IDENTITY, 8'h00);
        wreg(ADDR_SUMMARY, 8'hff);
        rchk(ADDR_CHIP_IDENTITY, CHIP_IDENTITY_VAL);
        rchk(ADDR_SUMMARY, 8'h00);
        wreg(ADDR_TTD, 8'hff);
        rchk(ADDR_TTD, 8'h7f);
        wreg(ADDR_DI, 8'h00);
        $display("test defaults done");
        // Keys 0 and 11 over threshold, integrator zero acting as one
        meas.over_thr <= 12'h801;
        wait_acq();
        chk({7'h0, chg_n}, 8'h00);
        rchk(ADDR_KEY_LO, 8'h01);
        rchk(ADDR_KEY_HI, 8'h08);
        rchk(ADDR_SUMMARY, 8'h01);
        @(posedge clk);
        meas.over_thr <= 12'h000;
        meas.slider_det <= 1;
        meas.slider_pos <= 8'h80;
        wait_acq();
        rchk(ADDR_KEY_LO, 8'h07);
        rchk(ADDR_SUMMARY, 8'h03);
        rchk(ADDR_SLIDER, 8'h80);
        @(posedge clk);
        meas <= '0;
        $display("test detect done");
        wreg(ADDR_CAL, 8'h00);
        rchk(ADDR_SUMMARY, 8'h00, 8'h80);
        wreg(ADDR_CAL, 8'h01);
        rchk(ADDR_SUMMARY, 8'h80, 8'h80);
        repeat (20) @(posedge clk);
        rchk(ADDR_SUMMARY, 8'h00, 8'h80);
        $display("test calibrate done");
        // Two waits so the sampled burst is surely a stretched one
        @(posedge clk);
        stretch <= 1;
        wait_acq();
        wait_acq();
        rchk(ADDR_SUMMARY, 8'h40, 8'h40);
        stretch <= 0;
        wait_acq();
        rchk(ADDR_SUMMARY, 8'h00, 8'h40);
        $display("test overflow done");
        pdn_chk(8'h00, 1'b1);
        pdn_chk(8'h02, 1'b0);
        pdn_chk(8'h00, 1'b1);
        wreg(ADDR_RESET, 8'h01);
        #1;
        chk({7'h0, srst}, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        chk({7'h0, pdn}, 8'h00);
        rchk(ADDR_LP, 8'h01);
        $display("test power done");
        // Soft reset above cleared the hold timer
        wreg(ADDR_TTD, 8'h00);
        wreg(ADDR_ATD, 8'h01);
        meas.above_ref <= 12'hfff;
        meas.below_ref <= 12'h004;
        watch(450);
        chk({7'h0, |up_seen}, 8'h00);
        chk(dn_seen[7:0], 8'h04);
        wreg(ADDR_TRD, 8'h01);
        meas.over_thr <= 12'h001;
        repeat (200) @(posedge clk);
        watch(450);
        chk(dn_seen[7:0], 8'h00);
        chk(rc_seen[7:0], 8'h01);
        $display("test drift done");
        // Second reset with the standalone strap
        @(posedge clk);
        meas <= '0;
        mode <= 1;
        rst_n <= 0;
        repeat (4) @(posedge clk);
        rst_n <= 1;
        repeat (4) @(posedge clk);
        rchk(ADDR_TRD, 8'hff);
        wreg(ADDR_TRD, 8'h00);
        wreg(ADDR_RESET, 8'h01);
        rchk(ADDR_TRD, 8'hff);
        $display("test strap done");
        tally_and_finish();
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
endmodule : tb

`default_nettype wire
